// File: core/uic_codec.sv
`timescale 1ns/100ps
`include "uic_params.svh"

// Behaviour
// - Enabled: encode UART transmit, decode receive pin.
// - Link is half-duplex; directions never overlap.
// - Bit timing from divisor: clk/(16*divisor).
// - Bit is 16 ticks; one stays low.
// - Zero: 7 low, 3 high, 6 low.
// - Enabled: modulated output replaces plain transmit pin.
// - Enabled: UART input fed from decoder.
// - Decoder counter runs 0 to 15.
// - Falling edge on input resets counter in idle or window, not in the first twelve counts.
// - Count eight updates regenerated input.
// - Window opens at twelve, closes at eight.
// - Pulse repeats cycle; none returns to idle.
// - Resync never disturbs the UART receiver.
// - One codec instance per UART channel.
module uic_codec #(
    parameter int DIV_WIDTH = 16
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_infrared_codec_enable,
    input  wire logic                 i_uart_enable,
    input  wire logic [DIV_WIDTH-1:0] i_divisor,
    input  wire logic                 i_uart_txd,
    input  wire logic                 i_rxd_pin,
    input  wire logic                 i_tx_busy,
    output logic                      o_txd_pin,
    output logic                      o_uart_rxd,
    output logic                      o_baud_tick
);
    logic                     tick;
    logic                     run;
    logic [3:0]               tx_phase_reg;
    logic                     tx_bit_reg;
    logic                     tx_active_reg;
    logic                     ir_modulated_out_reg;
    logic                     rx_meta_reg;
    logic                     ir_modulated_in_reg;
    logic                     rx_prev_reg;
    logic                     fall_seen_reg;
    logic [3:0]               rx_count_reg;
    logic                     pulse_in_bit_reg;
    logic                     rx_data_reg;
    logic                     uart_txd_sync_reg;
    logic                     uart_rxd_plain_reg;
    logic                     rx_meta_plain_reg;
    logic                     fall;
    uic_pkg::uic_rx_state_type rx_state_reg;

    assign run = i_uart_enable;

    // One generator per channel; instantiate this module once per UART.
    uic_baud_div #(
        .DIV_WIDTH (DIV_WIDTH)
    ) u_baud (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_run     (run),
        .i_divisor (i_divisor),
        .o_tick    (tick)
    );

    assign o_baud_tick = tick;

    // Encoder: phase counter starts at the first tick after enable and
    // samples the UART output once per bit at phase zero.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tx_phase_reg      <= 4'h0;
            tx_bit_reg        <= 1'b1;
            uart_txd_sync_reg <= 1'b1;
        end
        else if (!i_infrared_codec_enable || !run)
        begin
            tx_phase_reg      <= 4'h0;
            tx_bit_reg        <= 1'b1;
            uart_txd_sync_reg <= 1'b1;
        end
        else
        begin
            uart_txd_sync_reg <= i_uart_txd;
            if (tick)
            begin
                tx_phase_reg <= tx_phase_reg + 4'h1;
                if (tx_phase_reg == 4'h0)
                begin
                    tx_bit_reg <= uart_txd_sync_reg;
                end
            end
        end
    end

    // Zero bit: high only in phases 7..9 of the sixteen; a one stays low.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ir_modulated_out_reg <= `UIC_TX_IDLE_LEVEL;
        end
        else if (!i_infrared_codec_enable || !run)
        begin
            ir_modulated_out_reg <= `UIC_TX_IDLE_LEVEL;
        end
        else if (tick)
        begin
            ir_modulated_out_reg <= !tx_bit_reg
                && (tx_phase_reg >= 4'(`UIC_ZERO_LOW_TICKS))
                && (tx_phase_reg < 4'(`UIC_ZERO_LOW_TICKS + `UIC_ZERO_HIGH_TICKS));
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tx_active_reg <= 1'b0;
        end
        else
        begin
            tx_active_reg <= i_tx_busy;
        end
    end

    // Pin mux: the plain UART signals stay internal while the codec is on.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_txd_pin <= 1'b1;
        end
        else
        begin
            o_txd_pin <= i_infrared_codec_enable ? ir_modulated_out_reg : i_uart_txd;
        end
    end

    // Receive pin synchroniser.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_meta_reg         <= 1'b1;
            ir_modulated_in_reg <= 1'b1;
            rx_prev_reg         <= 1'b1;
            rx_meta_plain_reg   <= 1'b1;
            uart_rxd_plain_reg  <= 1'b1;
        end
        else
        begin
            rx_meta_reg         <= i_rxd_pin;
            ir_modulated_in_reg <= rx_meta_reg;
            rx_prev_reg         <= ir_modulated_in_reg;
            rx_meta_plain_reg   <= i_rxd_pin;
            uart_rxd_plain_reg  <= rx_meta_plain_reg;
        end
    end

    // Receive is ignored while transmitting, so the transceiver echo of our
    // own pulses is never decoded.
    assign fall = rx_prev_reg && !ir_modulated_in_reg && !tx_active_reg;

    // Fall edges are latched until the next tick so short pulses between
    // ticks are still seen.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            fall_seen_reg <= 1'b0;
        end
        else if (fall)
        begin
            fall_seen_reg <= 1'b1;
        end
        else if (tick)
        begin
            fall_seen_reg <= 1'b0;
        end
    end

    // Decoder state and counter; only the decoded level reaches the UART,
    // so resynchronising never moves the UART's own bit timing.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_state_reg     <= uic_pkg::UIC_RX_IDLE;
            rx_count_reg     <= 4'h0;
            pulse_in_bit_reg <= 1'b0;
            rx_data_reg      <= `UIC_RX_IDLE_LEVEL;
        end
        else if (!i_infrared_codec_enable || !run)
        begin
            rx_state_reg     <= uic_pkg::UIC_RX_IDLE;
            rx_count_reg     <= 4'h0;
            pulse_in_bit_reg <= 1'b0;
            rx_data_reg      <= `UIC_RX_IDLE_LEVEL;
        end
        else if (tick)
        begin
            unique case (rx_state_reg)
                uic_pkg::UIC_RX_IDLE:
                begin
                    if (fall_seen_reg)
                    begin
                        rx_state_reg     <= uic_pkg::UIC_RX_FIRST;
                        rx_count_reg     <= 4'h0;
                        pulse_in_bit_reg <= 1'b1;
                    end
                end
                uic_pkg::UIC_RX_FIRST:
                begin
                    rx_count_reg <= rx_count_reg + 4'h1;
                    if (rx_count_reg + 4'h1 == 4'(`UIC_RX_UPDATE_COUNT))
                    begin
                        rx_data_reg      <= !pulse_in_bit_reg;
                        pulse_in_bit_reg <= 1'b0;
                    end
                    if (rx_count_reg + 4'h1 == 4'(`UIC_RX_WINDOW_OPEN))
                    begin
                        rx_state_reg <= uic_pkg::UIC_RX_WINDOW;
                    end
                end
                uic_pkg::UIC_RX_WINDOW:
                begin
                    if (fall_seen_reg)
                    begin
                        rx_count_reg     <= 4'h0;
                        pulse_in_bit_reg <= 1'b1;
                        rx_state_reg     <= uic_pkg::UIC_RX_FIRST;
                    end
                    else if (rx_count_reg + 4'h1 == 4'(`UIC_RX_UPDATE_COUNT))
                    begin
                        rx_data_reg  <= !pulse_in_bit_reg;
                        rx_count_reg <= 4'h0;
                        rx_state_reg <= uic_pkg::UIC_RX_IDLE;
                    end
                    else
                    begin
                        rx_count_reg <= rx_count_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_uart_rxd <= `UIC_RX_IDLE_LEVEL;
        end
        else
        begin
            o_uart_rxd <= i_infrared_codec_enable ? rx_data_reg : uart_rxd_plain_reg;
        end
    end
endmodule : uic_codec

// File: core/uic_params.svh
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH

// Baud ticks per bit and the zero-bit pulse shape (low, high, low).
`define UIC_TICKS_PER_BIT    16
`define UIC_ZERO_LOW_TICKS   7
`define UIC_ZERO_HIGH_TICKS  3
`define UIC_ZERO_TAIL_TICKS  6
// Decoder counter values.
`define UIC_RX_UPDATE_COUNT  8
`define UIC_RX_WINDOW_OPEN   12
// Idle level of the regenerated UART input.
`define UIC_RX_IDLE_LEVEL    1'b1
// Modulated output level while idle.
`define UIC_TX_IDLE_LEVEL    1'b0

`endif

// File: core/uic_pkg.sv
package uic_pkg;
    typedef enum logic [1:0]
    {
        UIC_RX_IDLE,
        UIC_RX_FIRST,
        UIC_RX_WINDOW
    } uic_rx_state_type;
endpackage : uic_pkg

// File: core/uic_baud_div.sv
`timescale 1ns/100ps
`include "uic_params.svh"

// Baud-rate generator: one-cycle tick every i_divisor system clocks, so that a
// bit of 16 ticks lasts 16 x divisor clocks.
module uic_baud_div #(
    parameter int DIV_WIDTH = 16
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_run,
    input  wire logic [DIV_WIDTH-1:0] i_divisor,
    output logic                      o_tick
);
    logic [DIV_WIDTH-1:0] count_reg;

    // A divisor of zero behaves as one so the tick never stalls.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            count_reg <= '0;
            o_tick    <= 1'b0;
        end
        else if (!i_run)
        begin
            count_reg <= '0;
            o_tick    <= 1'b0;
        end
        else if (count_reg + DIV_WIDTH'(1) >= i_divisor)
        begin
            count_reg <= '0;
            o_tick    <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + DIV_WIDTH'(1);
            o_tick    <= 1'b0;
        end
    end
endmodule : uic_baud_div

// File: dv/uic_codec_props.sv
`timescale 1ns/100ps
module uic_codec_props #(
    parameter int DIV_WIDTH = 16
) (
    input wire logic                 i_clk,
    input wire logic                 i_nrst,
    input wire logic                 i_infrared_codec_enable,
    input wire logic                 i_uart_enable,
    input wire logic [DIV_WIDTH-1:0] i_divisor,
    input wire logic                 i_uart_txd,
    input wire logic                 i_rxd_pin,
    input wire logic                 i_tx_busy,
    input wire logic                 o_txd_pin,
    input wire logic                 o_uart_rxd,
    input wire logic                 o_baud_tick
);
    logic [7:0] txq_reg;
    logic [7:0] rxq_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Saturating, so a long quiet spell never wraps under the threshold.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst || !i_infrared_codec_enable || !i_uart_txd)
            txq_reg <= 8'h00;
        else if (o_baud_tick && txq_reg != 8'hff)
            txq_reg <= txq_reg + 8'h01;
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst || !i_infrared_codec_enable || (!i_rxd_pin && !i_tx_busy))
            rxq_reg <= 8'h00;
        else if (o_baud_tick && rxq_reg != 8'hff)
            rxq_reg <= rxq_reg + 8'h01;
    end
    AST_TICK_GAP: assert property (i_divisor == $past(i_divisor, 4) && i_divisor > 1
        && o_baud_tick |=> !o_baud_tick) else $error("tick on adjacent cycles");
    AST_UART_OFF: assert property (!i_uart_enable[*3] |-> !o_baud_tick)
        else $error("tick while uart off");
    AST_PLAIN_TX: assert property (!i_infrared_codec_enable[*2] ##0 $past(i_nrst)
        |-> o_txd_pin == $past(i_uart_txd)) else $error("plain transmit path wrong");
    AST_TX_IDLE: assert property (txq_reg > 8'd20 |-> !o_txd_pin)
        else $error("pulse during a one bit");
    AST_TX_PULSE: assert property ($rose(o_txd_pin) && i_infrared_codec_enable
        && i_divisor == 16'h0001 |-> o_txd_pin[*3] ##1 !o_txd_pin)
        else $error("pulse width wrong");
    AST_TX_GAP: assert property ($fell(o_txd_pin) && i_infrared_codec_enable
        && i_divisor == 16'h0001 |-> !o_txd_pin[*8]) else $error("low gap too short");
    AST_RX_IDLE: assert property (rxq_reg > 8'd32 |-> o_uart_rxd)
        else $error("receive output not idle high");
    AST_RX_ZERO: assert property ($fell(i_rxd_pin) && !i_tx_busy && rxq_reg > 8'd32
        && i_divisor == 16'h0001 |-> ##[8:16] !o_uart_rxd) else $error("zero not decoded");
endmodule : uic_codec_props
bind uic_codec uic_codec_props #(.DIV_WIDTH(DIV_WIDTH)) u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_infrared_codec_enable(i_infrared_codec_enable),
    .i_uart_enable(i_uart_enable), .i_divisor(i_divisor), .i_uart_txd(i_uart_txd),
    .i_rxd_pin(i_rxd_pin), .i_tx_busy(i_tx_busy), .o_txd_pin(o_txd_pin),
    .o_uart_rxd(o_uart_rxd), .o_baud_tick(o_baud_tick));

// File: dv/uic_ir_xcvr.sv
`timescale 1ns/100ps
module uic_ir_xcvr (
    input wire logic i_clk,
    input wire logic i_tick,
    input wire logic i_txd_pin,
    output logic     o_rxd_pin
);
    int pulses;
    int width;
    int run;
    initial o_rxd_pin = 1'b1;
    // Light pulses are counted; the width of the last one is kept in clocks.
    always @(posedge i_clk)
    begin
        if (i_txd_pin)
            run = run + 1;
        else if (run > 0)
        begin
            pulses = pulses + 1;
            width = run;
            run = 0;
        end
    end
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            while (!i_tick) @(posedge i_clk);
        end
        #1;
    endtask : ticks
    // Sent while the device is silent, and once with busy high to check that the echo is ignored.
    task automatic flash();
        o_rxd_pin = 1'b0;
        ticks(3);
        o_rxd_pin = 1'b1;
    endtask : flash
endmodule : uic_ir_xcvr

// File: dv/uic_codec_tb_top.sv
`timescale 1ns/100ps
module uic_codec_tb_top;
    logic        clk;
    logic        nrst;
    logic        en;
    logic        uen;
    logic [15:0] div;
    logic        txd;
    logic        busy;
    wire logic   pin;
    logic        txd_pin;
    logic        uart_rxd;
    logic        tick;
    int          bad_count;
    int          check_count;
    int          cycles;
    int          p;
    int          n;
    uic_codec #(.DIV_WIDTH(16)) dut (.i_clk(clk), .i_nrst(nrst),
        .i_infrared_codec_enable(en), .i_uart_enable(uen), .i_divisor(div),
        .i_uart_txd(txd), .i_rxd_pin(pin), .i_tx_busy(busy), .o_txd_pin(txd_pin),
        .o_uart_rxd(uart_rxd), .o_baud_tick(tick));
    uic_ir_xcvr xc (.i_clk(clk), .i_tick(tick), .i_txd_pin(txd_pin), .o_rxd_pin(pin));
    always #50 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            results();
        end
    end
    task automatic count_ticks(input int c);
        n = 0;
        repeat (c) @(posedge clk) n += int'(tick === 1'b1);
        #1;
    endtask : count_ticks
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        en = 1'b1;
        uen = 1'b1;
        div = 16'h0001;
        txd = 1'b1;
        busy = 1'b0;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        div = 16'h0003;
        count_ticks(8);
        count_ticks(30);
        check(n, 10);
        uen = 1'b0;
        count_ticks(4);
        count_ticks(20);
        check(n, 0);
        div = 16'h0001;
        uen = 1'b1;
        xc.ticks(8);
        p = xc.pulses;
        txd = 1'b0;
        xc.ticks(32);
        txd = 1'b1;
        xc.ticks(40);
        check(xc.pulses - p, 2);
        check(xc.width, 3);
        p = xc.pulses;
        xc.ticks(48);
        check(xc.pulses - p, 0);
        // Two zero bits, a pulse and then a second pulse that the window must accept.
        xc.flash();
        xc.ticks(13);
        xc.flash();
        xc.ticks(1);
        check(uart_rxd, 0);
        xc.ticks(16);
        check(uart_rxd, 0);
        xc.ticks(20);
        check(uart_rxd, 1);
        busy = 1'b1;
        xc.flash();
        xc.ticks(14);
        check(uart_rxd, 1);
        busy = 1'b0;
        en = 1'b0;
        txd = 1'b0;
        xc.o_rxd_pin = 1'b0;
        xc.ticks(6);
        check(txd_pin, 0);
        check(uart_rxd, 0);
        txd = 1'b1;
        xc.o_rxd_pin = 1'b1;
        xc.ticks(6);
        check(txd_pin, 1);
        check(uart_rxd, 1);
        en = 1'b1;
        xc.ticks(10);
        check(txd_pin, 0);
        results();
    end
endmodule : uic_codec_tb_top
